// [inc/nds_pkg.sv]
// package: diagnostic status register constants for the network controller
package nds_pkg;

    // ------------------------------------------------------------
    // register map (word index = byte address here, plain port)
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_DIAG_STATUS = 4'h0;
    localparam logic [3:0] ADDR_MASK        = 4'h1;
    localparam logic [3:0] ADDR_NODE_ID     = 4'h2;
    localparam logic [3:0] ADDR_TENT_ID     = 4'h3;
    localparam logic [3:0] ADDR_NEXT_ID     = 4'h4;
    localparam logic [3:0] ADDR_COMMAND     = 4'h5;
    localparam logic [3:0] ADDR_CTRL        = 4'h6;

    // ------------------------------------------------------------
    // diagnostic status bit positions
    // ------------------------------------------------------------
    localparam int BIT_OWN_LINE_IDLE_TIMEOUT_FLAG  = 7;
    localparam int BIT_DUP_NODE   = 6;
    localparam int BIT_LINE_ACT   = 5;
    localparam int BIT_TOKEN_SEEN = 4;
    localparam int BIT_EXC_REFUSE = 3;
    localparam int BIT_PROBE      = 2;
    localparam int BIT_SUCC_CHG   = 1;
    localparam int BIT_RESERVED   = 0;

    // ------------------------------------------------------------
    // command encoding: clear flags = 000r p110
    // ------------------------------------------------------------
    localparam logic [2:0] CMD_CLEAR_FLAGS = 3'h6;
    localparam int         CMD_P_BIT       = 3;
    localparam int         CMD_R_BIT       = 4;

    // ------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------
    localparam int CTRL_TX_EN      = 0;
    localparam int CTRL_ON_LINE    = 1;
    localparam int CTRL_NAK_LIMSEL = 2;

    // ------------------------------------------------------------
    // refusal limits and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] NAK_LIMIT_LONG  = 8'h80;
    localparam logic [7:0] NAK_LIMIT_SHORT = 8'h04;
    localparam logic [7:0] RST_BYTE        = 8'h00;
    localparam logic [7:0] RST_STATUS      = 8'h10;
    localparam int         POR_BIT         = 4;
    localparam int         LINE_IDLE_TIMEOUT_FLAG_BIT       = 2;

    typedef enum logic [1:0] {
        NDS_TOK_IDLE  = 2'b00,
        NDS_TOK_WAIT  = 2'b01,
        NDS_TOK_MATCH = 2'b10
    } nds_tok_state_t;

endpackage

// [rtl/nds_sync.sv]
// two-flop synchroniser for the serial receive pin
`timescale 1ns/1ps
module nds_sync (
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic d,
    output logic      q
);
    logic meta;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            meta <= 1'b0;
            q    <= 1'b0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule

// [rtl/nds_diag.sv]
// diagnostic status flags block of the token-passing network controller
// Functional notes
// - lost-token timeout sets bit 7
// - node id equals both destination bytes, answered
// - trailing zero bits must also be correct
// - on line: every own token sets duplicate flag
// - reading diagnostic register clears duplicate flag
// - high on serial receive sets bit 5
// - foreign token sets bit 4
// - 128 or 4 refusals set bit 3
// - excess flag survives reads, command clears it
// - first byte equals tentative id, answered
// - probe compare ignores second byte, zeros
// - next id update sets bit 1
// - next id read clears, diag read keeps
// - bit 0 reserved, reads zero
// - interrupt when excess, successor or line-idle flag and its mask bit set
// - clear-flags p bit clears power-up, excess
//
// Added by the designer: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
module nds_diag
    import nds_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic [3:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic      [7:0] rdata,
    output logic            irq,
    input  wire logic       serial_receive_in,
    input  wire logic       lost_token_timeout,
    input  wire logic       line_idle_timeout,
    input  wire logic       token_valid,
    input  wire logic [7:0] token_source,
    input  wire logic [7:0] destination_byte_a,
    input  wire logic [7:0] destination_byte_b,
    input  wire logic       trailer_ok,
    input  wire logic       token_response,
    input  wire logic       own_token,
    input  wire logic       refusal,
    input  wire logic       refusal_reset,
    input  wire logic       next_id_update,
    input  wire logic [7:0] next_id_value
);
    import nds_pkg::*;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    wire  [7:0]     diag;
    logic [7:0]     interrupt_mask_reg;
    logic [7:0]     node_id;
    logic [7:0]     tent_id;
    logic [7:0]     next_id;
    logic [7:0]     ctrl;
    logic [7:0]     status;
    logic [7:0]     nak_count;
    logic           rx_sync;
    logic           dup_hit;
    logic           probe_hit;
    nds_tok_state_t tok_state;
    logic [7:0]     flag_set;
    logic [7:0]     flag_clr;
    logic [2:0]     irq_src;

    wire wr_cmd   = wr && addr == ADDR_COMMAND;
    wire clr_cmd  = wr_cmd && wdata[2:0] == CMD_CLEAR_FLAGS
                    && wdata[7:5] == 3'h0;
    wire clr_p    = clr_cmd && wdata[CMD_P_BIT];
    wire clr_r    = clr_cmd && wdata[CMD_R_BIT];
    wire rd_diag  = rd && addr == ADDR_DIAG_STATUS;
    wire rd_next  = rd && addr == ADDR_NEXT_ID;
    wire on_line  = ctrl[CTRL_TX_EN] && ctrl[CTRL_ON_LINE];
    wire [7:0] nak_limit = ctrl[CTRL_NAK_LIMSEL] ? NAK_LIMIT_SHORT
                                                 : NAK_LIMIT_LONG;
    wire wr_mask  = wr && addr == ADDR_MASK;
    wire wr_node  = wr && addr == ADDR_NODE_ID;
    wire wr_tent  = wr && addr == ADDR_TENT_ID;
    wire wr_ctrl  = wr && addr == ADDR_CTRL;
    // a duplicate needs both bytes and clean trailing zeros
    wire dup_match   = destination_byte_a == node_id
                       && destination_byte_b == node_id
                       && trailer_ok;
    wire probe_match = destination_byte_a == tent_id;

    // ------------------------------------------------------------
    // pin synchroniser
    // ------------------------------------------------------------
    nds_sync u_rx_sync (
        .clk    (clk),
        .resetn (resetn),
        .d      (serial_receive_in),
        .q      (rx_sync)
    );

    // ------------------------------------------------------------
    // token tracking: match is latched at the token, judged on reply
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tok_state <= NDS_TOK_IDLE;
        end else begin
            case (tok_state)
                NDS_TOK_IDLE: begin
                    if (token_valid) begin
                        tok_state <= NDS_TOK_WAIT;
                    end
                end
                NDS_TOK_WAIT: begin
                    if (token_response) begin
                        tok_state <= NDS_TOK_MATCH;
                    end
                end
                NDS_TOK_MATCH: begin
                    tok_state <= NDS_TOK_IDLE;
                end
                default: begin
                    tok_state <= NDS_TOK_IDLE;
                end
            endcase
        end
    end

    wire answered = tok_state == NDS_TOK_MATCH;
    wire tok_take = token_valid
                    && (tok_state == NDS_TOK_IDLE
                        || (tok_state == NDS_TOK_WAIT && !token_response));

    // a newer token replaces one whose reply never came
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            dup_hit   <= 1'b0;
            probe_hit <= 1'b0;
        end else if (answered) begin
            dup_hit   <= 1'b0;
            probe_hit <= 1'b0;
        end else if (tok_take) begin
            dup_hit   <= dup_match;
            probe_hit <= probe_match;
        end
    end

    // ------------------------------------------------------------
    // refusal counter for the free-buffer query
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            nak_count <= RST_BYTE;
        end else if (refusal_reset) begin
            nak_count <= RST_BYTE;
        end else if (refusal && nak_count != nak_limit) begin
            nak_count <= nak_count + 8'h01;
        end
    end

    // count holds at the limit, so a long burst cannot wrap
    wire nak_reached = refusal && nak_count + 8'h01 >= nak_limit;

    // ------------------------------------------------------------
    // diagnostic flag events; a hardware set always beats any clear
    // ------------------------------------------------------------
    always_comb begin
        flag_set                 = 8'h00;
        flag_clr                 = 8'h00;
        flag_set[BIT_OWN_LINE_IDLE_TIMEOUT_FLAG]  = lost_token_timeout;
        flag_set[BIT_DUP_NODE]   = (answered && dup_hit)
                                   || (on_line && own_token);
        flag_clr[BIT_DUP_NODE]   = rd_diag;
        flag_set[BIT_LINE_ACT]   = rx_sync;
        flag_set[BIT_TOKEN_SEEN] = token_valid
                                   && token_source != node_id;
        flag_set[BIT_EXC_REFUSE] = nak_reached;
        flag_clr[BIT_EXC_REFUSE] = clr_p;
        flag_set[BIT_PROBE]      = answered && probe_hit;
        flag_set[BIT_SUCC_CHG]   = next_id_update;
        flag_clr[BIT_SUCC_CHG]   = rd_next;
        // reserved bit has no event, so it keeps its reset zero
        flag_set[BIT_RESERVED]   = 1'b0;
    end

    // ------------------------------------------------------------
    // one flop per flag bit
    // ------------------------------------------------------------
    for (genvar gi = 0; gi < 8; gi = gi + 1) begin : g_flag
        logic held;
        always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
                held <= RST_BYTE[gi];
            end else if (flag_set[gi]) begin
                held <= 1'b1;
            end else if (flag_clr[gi]) begin
                held <= 1'b0;
            end
        end
        assign diag[gi] = held;
    end

    // ------------------------------------------------------------
    // main status: power-up and line-idle flags
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            status <= RST_STATUS;
        end else begin
            if (wr_node && wdata == 8'h00) begin
                status[POR_BIT] <= 1'b1;
            end else if (clr_p) begin
                status[POR_BIT] <= 1'b0;
            end
            if (line_idle_timeout) begin
                status[LINE_IDLE_TIMEOUT_FLAG_BIT] <= 1'b1;
            end else if (clr_r) begin
                status[LINE_IDLE_TIMEOUT_FLAG_BIT] <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            interrupt_mask_reg <= RST_BYTE;
        end else if (wr_mask) begin
            interrupt_mask_reg <= wdata;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            node_id <= RST_BYTE;
        end else if (wr_node) begin
            node_id <= wdata;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tent_id <= RST_BYTE;
        end else if (wr_tent) begin
            tent_id <= wdata;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctrl <= RST_BYTE;
        end else if (wr_ctrl) begin
            ctrl <= wdata;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            next_id <= RST_BYTE;
        end else if (next_id_update) begin
            next_id <= next_id_value;
        end
    end

    // ------------------------------------------------------------
    // read port: data one cycle after the strobe, zero otherwise
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata <= RST_BYTE;
        end else if (rd) begin
            case (addr)
                ADDR_DIAG_STATUS: rdata <= diag;
                ADDR_MASK:        rdata <= interrupt_mask_reg;
                ADDR_NODE_ID:     rdata <= node_id;
                ADDR_TENT_ID:     rdata <= tent_id;
                ADDR_NEXT_ID:     rdata <= next_id;
                ADDR_COMMAND:     rdata <= status;
                ADDR_CTRL:        rdata <= ctrl;
                default:          rdata <= RST_BYTE;
            endcase
        end else begin
            rdata <= RST_BYTE;
        end
    end

    // ------------------------------------------------------------
    // interrupt sources, each gated by the mask bit at its position
    // ------------------------------------------------------------
    always_comb begin
        irq_src[0] = diag[BIT_EXC_REFUSE]
                     && interrupt_mask_reg[BIT_EXC_REFUSE];
        irq_src[1] = diag[BIT_SUCC_CHG]
                     && interrupt_mask_reg[BIT_SUCC_CHG];
        irq_src[2] = status[LINE_IDLE_TIMEOUT_FLAG_BIT]
                     && interrupt_mask_reg[LINE_IDLE_TIMEOUT_FLAG_BIT];
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |irq_src;
        end
    end

endmodule

// [tb/nds_diag_assertions.sv]
// port-level checker for the diagnostic flag block
`timescale 1ns/1ps
module nds_diag_chk
    import nds_pkg::*;
(
    input wire logic       clk,
    input wire logic       resetn,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr,
    input wire logic       rd,
    input wire logic [7:0] rdata,
    input wire logic       irq,
    input wire logic       serial_receive_in,
    input wire logic       lost_token_timeout,
    input wire logic       token_response,
    input wire logic       own_token,
    input wire logic       next_id_update
);
    logic [7:0] mask_sh;
    logic [2:0] quiet;
    logic       dread;
    logic       calm;
    assign dread = rd && addr == ADDR_DIAG_STATUS;
    // duplicate sources land a few edges late, so wait them out
    assign calm = quiet >= 3'h4 && !token_response && !own_token;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mask_sh <= 8'h00;
        end else if (wr && addr == ADDR_MASK) begin
            mask_sh <= wdata;
        end
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            quiet <= 3'h0;
        end else if (token_response || own_token) begin
            quiet <= 3'h0;
        end else if (quiet != 3'h7) begin
            quiet <= quiet + 3'h1;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // ----
    // properties
    // ----
    a_reserved_zero: assert property (
        $past(dread) |-> rdata[BIT_RESERVED] == 1'b0)
        else $error("reserved bit read as one");
    a_own_line_idle_timeout_flag: assert property (
        lost_token_timeout ##2 dread |=> rdata[BIT_OWN_LINE_IDLE_TIMEOUT_FLAG])
        else $error("lost token did not set bit 7");
    a_dup_rd_clr: assert property (
        dread && calm ##1 dread |=> !rdata[BIT_DUP_NODE])
        else $error("duplicate flag survived a read");
    a_line_act: assert property (
        serial_receive_in ##3 dread |=> rdata[BIT_LINE_ACT])
        else $error("receive activity not flagged");
    a_exc_sticky: assert property (
        $past(dread) && rdata[BIT_EXC_REFUSE] && dread
        |=> rdata[BIT_EXC_REFUSE])
        else $error("excess flag cleared by read");
    a_succ_keep: assert property (
        $past(dread) && rdata[BIT_SUCC_CHG] && dread
        |=> rdata[BIT_SUCC_CHG])
        else $error("successor flag cleared by read");
    a_succ_clear: assert property (
        rd && addr == ADDR_NEXT_ID && !next_id_update ##1 dread
        |=> !rdata[BIT_SUCC_CHG])
        else $error("successor flag kept after next id read");
    a_irq_masked: assert property (
        irq |-> ($past(mask_sh) & 8'h0e) != 8'h00)
        else $error("interrupt with all masks clear");
    c_dup_seen: cover property (dread ##1 rdata[BIT_DUP_NODE]);
    c_irq: cover property (irq);
    c_exc_seen: cover property ($past(dread) && rdata[BIT_EXC_REFUSE]);
endmodule

bind nds_diag nds_diag_chk u_chk (
    .clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .irq(irq),
    .serial_receive_in(serial_receive_in),
    .lost_token_timeout(lost_token_timeout),
    .token_response(token_response), .own_token(own_token),
    .next_id_update(next_id_update)
);

// [tb/nds_diag_tb.sv]
// testbench for the diagnostic flag block
`timescale 1ns/1ps
module network_diag_status_flags_tb_top;
    import nds_pkg::*;
    logic       clk = 1'b0;
    logic       resetn = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic       wr = 1'b0;
    logic       rd = 1'b0;
    logic [7:0] rdata;
    logic       irq;
    logic       rx = 1'b0;
    logic [7:0] ev = 8'h00;
    logic [7:0] src = 8'h00;
    logic [7:0] da = 8'h00;
    logic [7:0] db = 8'h00;
    logic       tr_ok = 1'b0;
    logic [7:0] nxt = 8'h00;
    logic [7:0] node;
    int         failures = 0;
    int         samples_checked = 0;
    int         cycles = 0;
    nds_diag u_dut (
        .clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .irq(irq),
        .serial_receive_in(rx), .lost_token_timeout(ev[0]),
        .line_idle_timeout(ev[1]), .token_valid(ev[2]),
        .token_source(src), .destination_byte_a(da),
        .destination_byte_b(db), .trailer_ok(tr_ok),
        .token_response(ev[3]), .own_token(ev[4]), .refusal(ev[5]),
        .refusal_reset(ev[6]), .next_id_update(ev[7]),
        .next_id_value(nxt)
    );
    initial begin
        forever #50 clk = ~clk;
    end
    // a hang costs a mismatch and still ends in the report
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            final_report();
        end
    end
    task automatic final_report();
        if (failures == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    // every task starts and ends just after an edge
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wreg(input logic [3:0] a, input logic [7:0] d);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
        #1;
    endtask
    task automatic rchk(input logic [3:0] a, input logic [7:0] m, e);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        check(rdata & m, e & m);
    endtask
    task automatic pulse(input int k);
        ev[k] <= 1'b1;
        @(posedge clk);
        ev[k] <= 1'b0;
        #1;
    endtask
    task automatic token(input logic [7:0] s, a, b, input logic t);
        src   <= s;
        da    <= a;
        db    <= b;
        tr_ok <= t;
        pulse(2);
        pulse(3);
        idle(4);
    endtask
    initial begin
        void'($urandom(90));
        node = 8'($urandom_range(254, 1));
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        idle(1);
        rchk(ADDR_DIAG_STATUS, 8'hff, 8'h00);
        rchk(ADDR_COMMAND, 8'h10, 8'h10);
        rchk(4'hf, 8'hff, 8'h00);
        pulse(0);
        idle(1);
        rchk(ADDR_DIAG_STATUS, 8'h80, 8'h80);
        wreg(ADDR_NODE_ID, node);
        wreg(ADDR_TENT_ID, ~node);
        pulse(4);
        token(node, node, node, 1'b0);
        rchk(ADDR_DIAG_STATUS, 8'h44, 8'h00);
        token(node, node, node, 1'b1);
        rchk(ADDR_DIAG_STATUS, 8'h40, 8'h40);
        rchk(ADDR_DIAG_STATUS, 8'h40, 8'h00);
        token(node, node, node ^ 8'h80, 1'b1);
        rchk(ADDR_DIAG_STATUS, 8'h44, 8'h00);
        token(node, ~node, 8'($urandom), 1'b0);
        rchk(ADDR_DIAG_STATUS, 8'h54, 8'h04);
        token(~node, 8'h00, 8'h00, 1'b1);
        rchk(ADDR_DIAG_STATUS, 8'h10, 8'h10);
        // long refusal limit is the reset choice
        repeat (127) pulse(5);
        rchk(ADDR_DIAG_STATUS, 8'h08, 8'h00);
        pulse(5);
        rchk(ADDR_DIAG_STATUS, 8'h08, 8'h08);
        wreg(ADDR_MASK, 8'h08);
        idle(2);
        check({7'h00, irq}, 8'h01);
        rchk(ADDR_DIAG_STATUS, 8'h08, 8'h08);
        rchk(ADDR_DIAG_STATUS, 8'h08, 8'h08);
        wreg(ADDR_COMMAND, 8'h0e);
        rchk(ADDR_DIAG_STATUS, 8'h08, 8'h00);
        rchk(ADDR_COMMAND, 8'h10, 8'h00);
        check({7'h00, irq}, 8'h00);
        wreg(ADDR_CTRL, 8'h07);
        pulse(6);
        repeat (3) pulse(5);
        rchk(ADDR_DIAG_STATUS, 8'h08, 8'h00);
        pulse(5);
        rchk(ADDR_DIAG_STATUS, 8'h08, 8'h08);
        ev[4] <= 1'b1;
        rchk(ADDR_DIAG_STATUS, 8'h40, 8'h00);
        ev[4] <= 1'b0;
        rchk(ADDR_DIAG_STATUS, 8'h40, 8'h40);
        wreg(ADDR_MASK, 8'h02);
        nxt <= 8'($urandom);
        pulse(7);
        rchk(ADDR_DIAG_STATUS, 8'h02, 8'h02);
        rchk(ADDR_DIAG_STATUS, 8'h02, 8'h02);
        check({7'h00, irq}, 8'h01);
        rchk(ADDR_NEXT_ID, 8'hff, nxt);
        rchk(ADDR_DIAG_STATUS, 8'h02, 8'h00);
        check({7'h00, irq}, 8'h00);
        wreg(ADDR_MASK, 8'h04);
        pulse(1);
        idle(1);
        check({7'h00, irq}, 8'h01);
        rchk(ADDR_COMMAND, 8'h04, 8'h04);
        wreg(ADDR_COMMAND, 8'h16);
        rchk(ADDR_COMMAND, 8'h04, 8'h00);
        idle(1);
        check({7'h00, irq}, 8'h00);
        rx <= 1'b1;
        idle(4);
        rchk(ADDR_DIAG_STATUS, 8'h20, 8'h20);
        final_report();
    end
endmodule
